//--- bench/axil_host.sv
// Host model that masters the register bus of the parameter word block.
// Assumes tasks are entered just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none

module axil_host (
  input  wire logic        clk,     // Clock.
  output logic             awvalid, // AW valid.
  input  wire logic        awready, // AW ready.
  output logic [3:0]       awaddr,  // AW address.
  output logic             wvalid,  // W valid.
  input  wire logic        wready,  // W ready.
  output logic [31:0]      wdata,   // W data.
  output logic [3:0]       wstrb,   // W strobes.
  input  wire logic        bvalid,  // B valid.
  output logic             bready,  // B ready.
  input  wire logic [1:0]  bresp,   // B code.
  output logic             arvalid, // AR valid.
  input  wire logic        arready, // AR ready.
  output logic [3:0]       araddr,  // AR address.
  input  wire logic        rvalid,  // R valid.
  output logic             rready,  // R ready.
  input  wire logic [31:0] rdata,   // R data.
  input  wire logic [1:0]  rresp    // R code.
);
  // Quiet bus at time zero.
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb} = 44'h0;
  end

  // Offers address and data, releases each when taken, then takes the answer.
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
          output logic [1:0] r);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a; // Released lines show no stale value.
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~d;
        wstrb <= ~s;
      end
    end
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  // Offers a read address, then holds rready until the data arrives.
  task rd(input logic [3:0] a, output logic [31:0] q, output logic [1:0] r);
    arvalid <= 1'b1;
    araddr <= a;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    q = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
endmodule : axil_host
`default_nettype wire

//--- bench/sfdp_params_properties.sv
// Checker of the parameter word register slave, bound to its top module.
// Assumes it sees only the top module's ports.
`timescale 1ns/10ps
`default_nettype none

module sfdp_params_check (
  input wire logic        clk,     // Clock.
  input wire logic        nrst,    // Reset.
  input wire logic        awvalid, // AW valid.
  input wire logic        awready, // AW ready.
  input wire logic        wvalid,  // W valid.
  input wire logic        wready,  // W ready.
  input wire logic        bvalid,  // B valid.
  input wire logic        bready,  // B ready.
  input wire logic [1:0]  bresp,   // B code.
  input wire logic        arvalid, // AR valid.
  input wire logic        arready, // AR ready.
  input wire logic [3:0]  araddr,  // AR address.
  input wire logic        rvalid,  // R valid.
  input wire logic        rready,  // R ready.
  input wire logic [31:0] rdata,   // R data.
  input wire logic [1:0]  rresp    // R code.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  localparam logic [31:0] prog_exp = {8'he1, 5'h1f, 5'h1f, 1'h1, 5'h09, 4'h8, 4'h1};
  localparam logic [31:0] susp_exp = {1'h0, 2'h2, 5'h09, 4'h1, 2'h2, 5'h09, 4'h1,
                                      1'h1, 4'he, 4'hc};
  logic [3:0] rd_addr_r; // Address of the read in flight.

  // Remembers the address of the read in flight.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_addr_r <= 4'h0;
    end else if (arvalid && arready) begin
      rd_addr_r <= araddr;
    end
  end

  sequence s_rd_ans; !rvalid ##1 rvalid; endsequence
  sequence s_wr_ans; !bvalid ##1 bvalid; endsequence
  property p_rd_lat; arvalid && arready |=> s_rd_ans; endproperty
  property p_rd_hold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  property p_rd_rel; rvalid && rready |=> !rvalid && arready; endproperty
  property p_busy; rvalid |-> !arready; endproperty
  property p_prog; rvalid && rd_addr_r[3:2] == 2'h0 |-> rdata == prog_exp; endproperty
  property p_susp; rvalid && rd_addr_r[3:2] == 2'h1 |-> rdata == susp_exp; endproperty
  property p_wr_lat; awvalid && awready && wvalid && wready && !bvalid |=> s_wr_ans;
  endproperty
  property p_wr_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  property p_wr_code; bvalid |-> bresp != sfdp_param_pkg::resp_decerr; endproperty

  a_rd_lat: assert property (p_rd_lat) else $error("read answer late or early");
  a_rd_hold: assert property (p_rd_hold) else $error("read answer not held");
  a_rd_rel: assert property (p_rd_rel) else $error("read not released");
  a_busy: assert property (p_busy) else $error("read taken while busy");
  a_prog: assert property (p_prog) else $error("timing word wrong");
  a_susp: assert property (p_susp) else $error("suspend word wrong");
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late or early");
  a_wr_hold: assert property (p_wr_hold) else $error("write answer not held");
  a_wr_code: assert property (p_wr_code) else $error("write refused as unmapped");
endmodule : sfdp_params_check

bind sfdp_program_suspend_params sfdp_params_check chk_u (
  .clk, .nrst, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .bresp,
  .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
`default_nettype wire

//--- bench/sfdp_program_suspend_params_test.sv
// Self-checking bench for the parameter word register slave.
// Assumes the host model masters the bus and the checker is bound.
`timescale 1ns/10ps
`default_nettype none

`define check_eq(got, exp) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp); \
  end \
end

module sfdp_program_suspend_params_test;
  logic        clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, en_m;
  logic [3:0]  awaddr, wstrb, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [15:0] wr_m, rd_m;
  int          err_total, n_checks, seed;

  // Clock of 50 ns period.
  always #25 clk = ~clk;

  sfdp_program_suspend_params dut_u (.clk, .nrst, .awvalid, .awready, .awaddr,
    .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp);
  axil_host host_u (.clk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp);

  // Expected read data from the field values and the bench's own counters.
  function automatic logic [31:0] exp_q(input logic [3:0] a);
    case (a[3:2])
      2'h0:    exp_q = {8'he1, 5'h1f, 5'h1f, 1'h1, 5'h09, 4'h8, 4'h1};
      2'h1:    exp_q = {1'h0, 2'h2, 5'h09, 4'h1, 2'h2, 5'h09, 4'h1, 1'h1, 4'he, 4'hc};
      2'h2:    exp_q = {31'h0, en_m};
      default: exp_q = {rd_m, wr_m};
    endcase
  endfunction : exp_q

  // Expected write answer: read-only places are refused only when errors are on.
  function automatic logic [1:0] exp_b(input logic [3:0] a);
    exp_b = (a[3:2] != 2'h2 && en_m) ? sfdp_param_pkg::resp_slverr : sfdp_param_pkg::resp_okay;
  endfunction : exp_b

  // One bus operation with its comparisons and the model update.
  task automatic op(input logic w, input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic [31:0] q;
    logic [1:0]  r;
    if (w) begin
      host_u.wr(a, d, s, r);
      `check_eq(r, exp_b(a))
      if (!a[3]) wr_m++;
      if (a[3:2] == 2'h2 && s[0]) begin
        en_m = d[0];
        if (d[1]) {wr_m, rd_m} = 32'h0;
      end
    end else begin
      host_u.rd(a, q, r);
      `check_eq(q, exp_q(a))
      `check_eq(r, sfdp_param_pkg::resp_okay)
      if (!a[3]) rd_m++;
    end
  endtask : op

  // Prints the counts and the verdict, then ends the run.
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  // Main sequence: reset, corner cases, random traffic, final reads.
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    seed = 21;
    err_total = 0;
    n_checks = 0;
    en_m = 1'b0;
    {wr_m, rd_m} = 32'h0;
    repeat (8) @(posedge clk);
    `check_eq({awready, wready, arready, bvalid, rvalid}, 5'h1c)
    nrst <= 1'b1;
    @(posedge clk);
    $display("test reset done");
    op(1'b0, 4'h1, 32'h0, 4'h0);
    op(1'b0, 4'h7, 32'h0, 4'h0);
    op(1'b1, 4'h0, 32'h0, 4'hf);
    op(1'b1, 4'h4, 32'hffffffff, 4'hf);
    op(1'b1, 4'h8, 32'h1, 4'h1);
    op(1'b1, 4'h4, 32'h0, 4'hf);
    op(1'b1, 4'hc, 32'h5, 4'hf);
    op(1'b0, 4'h8, 32'h0, 4'h0);
    op(1'b0, 4'hc, 32'h0, 4'h0);
    op(1'b1, 4'h8, 32'h2, 4'he);
    op(1'b1, 4'h8, 32'h2, 4'h1);
    op(1'b0, 4'hc, 32'h0, 4'h0);
    $display("test corner done");
    repeat (80) op(1'($random(seed)), 4'($random(seed)), 32'($random(seed)),
                   4'($random(seed)));
    $display("test random done");
    op(1'b0, 4'h0, 32'h0, 4'h0);
    op(1'b0, 4'h4, 32'h0, 4'h0);
    $display("test final reads done");
    final_report();
  end

  // Watchdog against a hung handshake.
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    $display("watchdog expired");
    final_report();
  end
endmodule : sfdp_program_suspend_params_test
`default_nettype wire

//--- core/axil_wr_capture.sv
// Holds an AXI4-Lite write address and write data, taken in either order.
// Assumes the owner pulses take only while pend is high.
`timescale 1ns/10ps
`default_nettype none

module axil_wr_capture (
  input  wire logic        clk,        // System clock.
  input  wire logic        nrst,       // Asynchronous reset, active low.
  input  wire logic        awvalid,    // Write address valid.
  output logic             awready,    // Write address ready.
  input  wire logic [3:0]  awaddr,     // Write address.
  input  wire logic        wvalid,     // Write data valid.
  output logic             wready,     // Write data ready.
  input  wire logic [31:0] wdata,      // Write data.
  input  wire logic [3:0]  wstrb,      // Byte strobes.
  input  wire logic        take,       // Owner consumes the pair.
  output logic             pend,       // Address and data both held.
  output logic [3:0]       pend_addr,  // Held address.
  output logic [31:0]      pend_data,  // Held data.
  output logic [3:0]       pend_strb   // Held strobes.
);

  typedef struct packed {
    logic        aw_full;
    logic        w_full;
    logic        awready;
    logic        wready;
    logic [3:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } state_type;

  state_type state_r;
  state_type state_nxt;

  // Each channel closes once it holds an item and reopens after take.
  always_comb begin
    state_nxt = state_r;
    if (take) begin
      state_nxt.aw_full = 1'b0;
      state_nxt.w_full  = 1'b0;
    end
    if (awvalid && state_r.awready) begin
      state_nxt.aw_full = 1'b1;
      state_nxt.addr    = awaddr;
    end
    if (wvalid && state_r.wready) begin
      state_nxt.w_full = 1'b1;
      state_nxt.data   = wdata;
      state_nxt.strb   = wstrb;
    end
    state_nxt.awready = !state_nxt.aw_full;
    state_nxt.wready  = !state_nxt.w_full;
  end

  // Readies come up high right after reset.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r         <= '0;
      state_r.awready <= 1'b1;
      state_r.wready  <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign awready   = state_r.awready;
  assign wready    = state_r.wready;
  assign pend      = state_r.aw_full && state_r.w_full;
  assign pend_addr = state_r.addr;
  assign pend_data = state_r.data;
  assign pend_strb = state_r.strb;

endmodule : axil_wr_capture

`default_nettype wire

//--- core/param_word_rom.sv
// Two-word table of the fixed parameter words with a registered output.
// Assumes the caller holds the select for the cycle in which rd_en is high.
`timescale 1ns/10ps
`default_nettype none

module param_word_rom (
  input  wire logic        clk,      // System clock.
  input  wire logic        nrst,     // Asynchronous reset, active low.
  input  wire logic        rd_en,    // Load the output register.
  input  wire logic        rd_sel,   // 0 timing word, 1 suspend word.
  output logic [31:0]      rd_data   // Registered word.
);

  typedef struct packed {
    logic [31:0] q;
  } state_type;

  state_type state_r;
  state_type state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (rd_en) begin
      state_nxt.q = rd_sel ? sfdp_param_pkg::susp_word : sfdp_param_pkg::prog_word;
    end
  end

  // The table itself has no storage; only the output is a flip-flop.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rd_data = state_r.q;

endmodule : param_word_rom

`default_nettype wire

//--- core/sfdp_param_pkg.sv
// Constants for the program timing and suspend parameter words block.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned offsets.
package sfdp_param_pkg;

  // ********************************************************************
  // Register map and bus answers
  // ********************************************************************
  localparam int          addr_w        = 4;
  localparam logic [3:0]  ofs_prog_word = 4'h0;
  localparam logic [3:0]  ofs_susp_word = 4'h4;
  localparam logic [3:0]  ofs_ctrl      = 4'h8;
  localparam logic [3:0]  ofs_status    = 4'hc;
  localparam logic [1:0]  resp_okay     = 2'h0;
  localparam logic [1:0]  resp_slverr   = 2'h2;
  localparam logic [1:0]  resp_decerr   = 2'h3;

  // ********************************************************************
  // Control and status fields
  // ********************************************************************
  localparam int          ctrl_err_bit  = 0;
  localparam int          ctrl_clr_bit  = 1;
  localparam logic        ctrl_err_rst  = 1'h0;
  localparam logic [15:0] count_rst     = 16'h0000;
  localparam logic [15:0] count_max     = 16'hffff;

  // ********************************************************************
  // Program timing word fields, msb first
  // ********************************************************************
  localparam logic [7:0]  pw_upper      = 8'he1;   // Bits 31:24, chip erase field.
  localparam logic [4:0]  pw_byte_next  = 5'h1f;   // Bits 23:19, not specified.
  localparam logic [4:0]  pw_byte_first = 5'h1f;   // Bits 18:14, not specified.
  localparam logic        pw_pp_unit    = 1'h1;    // Bit 13.
  localparam logic [4:0]  pw_pp_count   = 5'h09;   // Bits 12:8.
  localparam logic [3:0]  pw_page_exp   = 4'h8;    // Bits 7:4.
  localparam logic [3:0]  pw_pp_mult    = 4'h1;    // Bits 3:0.
  localparam logic [31:0] prog_word     = {pw_upper, pw_byte_next, pw_byte_first,
                                           pw_pp_unit, pw_pp_count, pw_page_exp,
                                           pw_pp_mult};

  // ********************************************************************
  // Suspend and resume word fields, msb first
  // ********************************************************************
  // suspend supported
  localparam logic        sw_unsupp     = 1'h0;    // Bit 31.
  localparam logic [1:0]  sw_ers_unit   = 2'h2;    // Bits 30:29.
  localparam logic [4:0]  sw_ers_count  = 5'h09;   // Bits 28:24.
  localparam logic [3:0]  sw_ers_gap    = 4'h1;    // Bits 23:20.
  localparam logic [1:0]  sw_prg_unit   = 2'h2;    // Bits 19:18.
  localparam logic [4:0]  sw_prg_count  = 5'h09;   // Bits 17:13.
  localparam logic [3:0]  sw_prg_gap    = 4'h1;    // Bits 12:9.
  localparam logic        sw_rsv        = 1'h1;    // Bit 8.
  localparam logic [3:0]  sw_ers_block  = 4'he;    // Bits 7:4.
  localparam logic [3:0]  sw_prg_block  = 4'hc;    // Bits 3:0.
  localparam logic [31:0] susp_word     = {sw_unsupp, sw_ers_unit, sw_ers_count,
                                           sw_ers_gap, sw_prg_unit, sw_prg_count,
                                           sw_prg_gap, sw_rsv, sw_ers_block,
                                           sw_prg_block};

endpackage : sfdp_param_pkg

//--- core/sfdp_program_suspend_params.sv
// Register slave that serves the program timing and suspend parameter words.
// Assumes an AXI4-Lite master on clk, one write and one read at most at a time.
// Control and status words sit beside the two fixed words.
// Reads and writes proceed independently of each other.
`timescale 1ns/10ps
`default_nettype none

module sfdp_program_suspend_params (
  input  wire logic        clk,      // System clock, 20 MHz.
  input  wire logic        nrst,     // Asynchronous reset, active low.
  input  wire logic        awvalid,  // Write address valid.
  output logic             awready,  // Write address ready.
  input  wire logic [3:0]  awaddr,   // Write byte address.
  input  wire logic [2:0]  awprot,   // Write protection, unused.
  input  wire logic        wvalid,   // Write data valid.
  output logic             wready,   // Write data ready.
  input  wire logic [31:0] wdata,    // Write data.
  input  wire logic [3:0]  wstrb,    // Write byte strobes.
  output logic             bvalid,   // Write response valid.
  input  wire logic        bready,   // Write response ready.
  output logic [1:0]       bresp,    // Write response code.
  input  wire logic        arvalid,  // Read address valid.
  output logic             arready,  // Read address ready.
  input  wire logic [3:0]  araddr,   // Read byte address.
  input  wire logic [2:0]  arprot,   // Read protection, unused.
  output logic             rvalid,   // Read data valid.
  input  wire logic        rready,   // Read data ready.
  output logic [31:0]      rdata,    // Read data.
  output logic [1:0]       rresp     // Read response code.
);

  // ********************************************************************
  // Types and state
  // ********************************************************************

  // Read channel sequence: wait for an address, load the data, hold it.
  // The table output is registered, so one load cycle sits between the
  // address handshake and the read data.
  // The address channel stays closed until the data are taken.
  typedef enum logic [2:0] {
    rd_idle = 3'b001,
    rd_load = 3'b010,
    rd_resp = 3'b100
  } rd_state_type;

  // Everything the slave remembers between clock edges.
  // Write address and data are held in the capture submodule.
  typedef struct packed {
    rd_state_type rd_state;
    logic [3:0]   rd_addr;
    logic         arready;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         err_en;
    // Attempt and read counts shown in the status word.
    logic [15:0]  wr_ignored;
    logic [15:0]  rd_count;
  } state_type;

  // Registered state and its next value.
  state_type   state_r;
  state_type   state_nxt;

  // Held write pair and its consume strobe.
  logic        wr_pend;
  logic [3:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_take;

  // Read address take and the table word.
  logic        rd_take;
  logic [31:0] rom_data;

  // Unused protection inputs, folded.
  logic        unused_prot;

  // ********************************************************************
  // Helper functions
  // ********************************************************************

  // Word offset of a byte address; the two low bits are ignored.
  function automatic logic [3:0] word_ofs(input logic [3:0] addr);
    return {addr[3:2], 2'b00};
  endfunction : word_ofs

  // True for the word offset of either fixed parameter word.
  function automatic logic is_param_word(input logic [3:0] addr);
    return (word_ofs(addr) == sfdp_param_pkg::ofs_prog_word) ||
           (word_ofs(addr) == sfdp_param_pkg::ofs_susp_word);
  endfunction : is_param_word

  // True for the control register.
  function automatic logic is_ctrl(input logic [3:0] addr);
    return word_ofs(addr) == sfdp_param_pkg::ofs_ctrl;
  endfunction : is_ctrl

  // True for the status register.
  function automatic logic is_status(input logic [3:0] addr);
    return word_ofs(addr) == sfdp_param_pkg::ofs_status;
  endfunction : is_status

  // True for any offset that the slave decodes.
  function automatic logic is_mapped(input logic [3:0] addr);
    return is_param_word(addr) || is_ctrl(addr) || is_status(addr);
  endfunction : is_mapped

  // ********************************************************************
  // Counters
  // ********************************************************************

  // Saturating event counter; an event in the clearing cycle still counts.
  // A counter stops at its top value instead of wrapping to zero.
  function automatic logic [15:0] next_count(input logic [15:0] cnt,
                                             input logic        inc,
                                             input logic        clr);
    logic [15:0] base;
    base = clr ? sfdp_param_pkg::count_rst : cnt;
    if (inc && (base != sfdp_param_pkg::count_max)) begin
      base = base + 16'h0001;
    end
    return base;
  endfunction : next_count

  // ********************************************************************
  // Submodules
  // ********************************************************************

  // Both submodules run on the slave's clock and reset.

  // Holds write address and data until both have arrived.
  // Its readies stay low while a pair is held, stalling the master.
  axil_wr_capture u_wr_capture (
    .clk       (clk),
    .nrst      (nrst),
    .awvalid   (awvalid),
    .awready   (awready),
    .awaddr    (awaddr),
    .wvalid    (wvalid),
    .wready    (wready),
    .wdata     (wdata),
    .wstrb     (wstrb),
    .take      (wr_take),
    .pend      (wr_pend),
    .pend_addr (wr_addr),
    .pend_data (wr_data),
    .pend_strb (wr_strb)
  );

  // Address bit 2 tells the two fixed words apart.
  // words from table
  param_word_rom u_word_rom (
    .clk     (clk),
    .nrst    (nrst),
    .rd_en   (rd_take),
    .rd_sel  (araddr[2]),
    .rd_data (rom_data)
  );

  // ********************************************************************
  // Handshake terms
  // ********************************************************************

  // A read address is taken at the edge where valid meets ready.
  // The table loads at that same edge from the address then standing.
  assign rd_take = arvalid && state_r.arready;

  // A held write pair is consumed only while no response is outstanding.
  // This keeps an unaccepted response from being overwritten.
  assign wr_take = wr_pend && !state_r.bvalid;

  // Protection bits carry no meaning for this slave.
  // The reduction only keeps the inputs from being left unread.
  assign unused_prot = ^{awprot, arprot};

  // ********************************************************************
  // Next state
  // ********************************************************************

  // Read sequence, write effects, control and counters.
  // Locals get defaults first so no path leaves them unassigned.
  always_comb begin
    logic ctrl_hit;
    logic clr_cnt;
    logic ro_hit;
    logic rd_word;

    ctrl_hit  = 1'b0;
    clr_cnt   = 1'b0;
    ro_hit    = 1'b0;
    rd_word   = 1'b0;
    state_nxt = state_r;

    // Read channel.
    case (state_r.rd_state)

      // Idle: take an address and close the address channel.
      rd_idle: begin
        if (rd_take) begin
          state_nxt.rd_addr  = araddr;
          state_nxt.arready  = 1'b0;
          state_nxt.rd_state = rd_load;
        end
      end

      // Load: the table word is valid now and moves to the read data.
      rd_load: begin
        state_nxt.rvalid   = 1'b1;
        state_nxt.rresp    = sfdp_param_pkg::resp_okay;
        state_nxt.rd_state = rd_resp;
        if (is_param_word(state_r.rd_addr)) begin
          state_nxt.rdata = rom_data;
          rd_word         = 1'b1;
        end else if (is_ctrl(state_r.rd_addr)) begin
          // Control reads return the error enable alone.
          state_nxt.rdata = {31'h00000000, state_r.err_en};
        end else if (is_status(state_r.rd_addr)) begin
          // Status packs the read count above the write count.
          state_nxt.rdata = {state_r.rd_count, state_r.wr_ignored};
        end else begin
          // Kept for a wider map; every 4-bit offset is decoded.
          state_nxt.rdata = 32'h00000000;
          state_nxt.rresp = sfdp_param_pkg::resp_decerr;
        end
      end

      // Respond: data and code stand until the master takes them.
      rd_resp: begin
        if (rready) begin
          state_nxt.rvalid   = 1'b0;
          state_nxt.arready  = 1'b1;
          state_nxt.rd_state = rd_idle;
        end
      end

      // An illegal state code returns the channel to idle.
      default: begin
        state_nxt.rvalid   = 1'b0;
        state_nxt.arready  = 1'b1;
        state_nxt.rd_state = rd_idle;
      end

    endcase

    // Write response retires when the master accepts it.
    // A new pair waits while this response stands.
    if (state_r.bvalid && bready) begin
      state_nxt.bvalid = 1'b0;
    end

    // Write effects at the edge where the held pair is consumed.
    // Read-only targets keep their value; the code may report the try.
    if (wr_take) begin
      state_nxt.bvalid = 1'b1;
      state_nxt.bresp  = sfdp_param_pkg::resp_okay;
      ctrl_hit = is_ctrl(wr_addr) && wr_strb[0];
      ro_hit   = is_param_word(wr_addr);

      // Unmapped space answers with a decode error.
      if (!is_mapped(wr_addr)) begin
        state_nxt.bresp = sfdp_param_pkg::resp_decerr;
      end else if (ro_hit || is_status(wr_addr)) begin
        if (state_r.err_en) begin
          state_nxt.bresp = sfdp_param_pkg::resp_slverr;
        end
      end

      // Only the low byte lane carries control bits.
      if (ctrl_hit) begin
        state_nxt.err_en = wr_data[sfdp_param_pkg::ctrl_err_bit];
        clr_cnt          = wr_data[sfdp_param_pkg::ctrl_clr_bit];
      end
    end

    // Counters; the clear bit is a pulse and never stored.
    // An event in the clearing cycle survives, so none is lost.
    state_nxt.wr_ignored = next_count(state_r.wr_ignored, ro_hit, clr_cnt);
    state_nxt.rd_count   = next_count(state_r.rd_count, rd_word, clr_cnt);
  end

  // ********************************************************************
  // State register
  // ********************************************************************

  // Reset opens the read address channel and clears every counter.
  // The struct resets to zero first; named fields follow.
  // Only constants appear here, as an asynchronous reset needs.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r            <= '0;
      state_r.rd_state   <= rd_idle;
      state_r.arready    <= 1'b1;
      state_r.err_en     <= sfdp_param_pkg::ctrl_err_rst;
      state_r.wr_ignored <= sfdp_param_pkg::count_rst;
      state_r.rd_count   <= sfdp_param_pkg::count_rst;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************

  // Every output comes straight from a flip-flop.
  // The write readies come from the capture flip-flops.

  // Read channel outputs.
  assign arready = state_r.arready;
  assign rvalid  = state_r.rvalid;
  assign rdata   = state_r.rdata;
  assign rresp   = state_r.rresp;

  // Write response outputs.
  assign bvalid  = state_r.bvalid;
  assign bresp   = state_r.bresp;

endmodule : sfdp_program_suspend_params

`default_nettype wire
